// file: rtl/act_params.svh
// constants for the adc computation and threshold register block
// assumes: included by the design files, register index = byte addr / 4
`ifndef ACT_PARAMS_SVH
`define ACT_PARAMS_SVH

// ************************************************************
// register indices (byte address is four times the index)
// ************************************************************
`define ACT_IDX_W          12
`define ACT_IDX_LTH_L      12'h3D9
`define ACT_IDX_LTH_H      12'h3DA
`define ACT_IDX_UTH_L      12'h3DB
`define ACT_IDX_UTH_H      12'h3DC
`define ACT_IDX_ERR_L      12'h3DD
`define ACT_IDX_ERR_H      12'h3DE
`define ACT_IDX_TGT_L      12'h3DF
`define ACT_IDX_TGT_H      12'h3E0
`define ACT_IDX_FLT_L      12'h3E1
`define ACT_IDX_FLT_H      12'h3E2
`define ACT_IDX_SUM_L      12'h3E3
`define ACT_IDX_SUM_H      12'h3E4
`define ACT_IDX_SUM_U      12'h3E5
`define ACT_IDX_TALLY      12'h3E6
`define ACT_IDX_LIMIT      12'h3E7
`define ACT_IDX_PREV_L     12'h3E8
`define ACT_IDX_PREV_H     12'h3E9
`define ACT_IDX_RES_L      12'h3EA
`define ACT_IDX_RES_H      12'h3EB
`define ACT_IDX_CAP        12'h3F0
`define ACT_IDX_CTRL0      12'h3D0
`define ACT_IDX_CTRL1      12'h3D1
`define ACT_IDX_CTRL2      12'h3D2
`define ACT_IDX_STAT       12'h3D3
`define ACT_IDX_IRQ_STAT   12'h3D4
`define ACT_IDX_IRQ_CLR    12'h3D5
`define ACT_IDX_IRQ_EN     12'h3D6

// ************************************************************
// field positions
// ************************************************************
`define ACT_CTRL0_MODE     2:0
`define ACT_CTRL0_JUSTIFY  3
`define ACT_CTRL0_SNAPSHOT_SOURCE_SEL     4
`define ACT_CTRL1_SHIFT    2:0
`define ACT_CTRL1_DEVIATION_METHOD     5:4
`define ACT_CTRL2_TMD      2:0
`define ACT_STAT_BELOW     0
`define ACT_STAT_ABOVE     1
`define ACT_STAT_ACTIVE    2
`define ACT_IRQ_THRESH     0
`define ACT_IRQ_DONE       1
`define ACT_IRQ_W          2
`define ACT_CAP_W          5

// ************************************************************
// reset values
// ************************************************************
`define ACT_RST_16         16'h0000
`define ACT_RST_8          8'h00
`define ACT_RST_SUM        18'h00000
`define ACT_RST_CAP        5'h00
`define ACT_RST_IRQ        2'h0

`endif

// file: rtl/act_pkg.sv
// types for the adc computation and threshold register block
// assumes: compiled before act_regs
package act_pkg;

   typedef enum logic [2:0] {
      ACT_MODE_BASIC,
      ACT_MODE_ACCUM,
      ACT_MODE_AVG,
      ACT_MODE_BURST,
      ACT_MODE_LPF
   } act_mode_t;

   typedef enum logic [1:0] {
      ACT_DEV_RES_PREV,
      ACT_DEV_RES_TGT,
      ACT_DEV_FLT_TGT,
      ACT_DEV_FLT_PREV
   } act_dev_t;

   typedef enum logic [2:0] {
      ACT_TMD_NEVER,
      ACT_TMD_BELOW,
      ACT_TMD_NOT_BELOW,
      ACT_TMD_OUTSIDE,
      ACT_TMD_INSIDE,
      ACT_TMD_ABOVE,
      ACT_TMD_NOT_ABOVE,
      ACT_TMD_ALWAYS
   } act_tmd_t;

endpackage

// file: rtl/act_regs.sv
// computation back end: sum, filter, snapshot, tally, threshold check
// assumes: converter strobes are synchronous to pclk; apb master on pclk
//
// Notes on behaviour
// - eight-bit repeat limit gates threshold check
// - eight-bit writable tally counts triggers
// - check when tally reaches limit
// - tally only in filter, burst, average
// - filtered output is sum shifted right
// - filter mode shows low-pass output
// - source one snapshots filtered at start
// - source zero snapshots justified sample
// - sum 18-bit signed, upper bits sign
// - sum writable only when idle
// - deviation per selected method and target
// - bounds compare sets below, above flags
// - threshold interrupt per selected condition
// - bounds are signed 16-bit read/write
// - five-bit extra capacitance, zero none
// - every multi-byte register has byte aliases
`timescale 1ns/1ps
`include "act_params.svh"

module act_regs #(
   parameter int SAMPLE_W = 12
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 clk_en,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [13:0]          paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic                 conv_start,
   input  wire logic                 conv_done,
   input  wire logic [SAMPLE_W-1:0]  conv_data,
   output logic      [`ACT_CAP_W-1:0] extra_sample_pf,
   output logic                      conversion_active,
   output logic                      irq
);

   // ************************************************************
   // elaboration check
   // ************************************************************
   if (SAMPLE_W < 1 || SAMPLE_W > 15) begin : g_chk
      $error("SAMPLE_W must be 1 to 15");
   end

   // ************************************************************
   // state
   // ************************************************************
   logic signed [15:0] lower_bound_reg;
   logic signed [15:0] upper_bound_reg;
   logic signed [15:0] setpoint_deviation_reg;
   logic signed [15:0] target_level_reg;
   logic signed [15:0] filtered_out_reg;
   logic signed [17:0] running_sum_reg;
   logic        [7:0]  trigger_tally_reg;
   logic        [7:0]  tally_limit_reg;
   logic        [15:0] last_sample_snapshot_reg;
   logic        [15:0] sample_value_reg;
   logic        [`ACT_CAP_W-1:0] extra_sample_pf_reg;
   logic        [7:0]  ctrl0_reg;
   logic        [7:0]  ctrl1_reg;
   logic        [7:0]  ctrl2_reg;
   logic               below_low_flag;
   logic               above_high_flag;
   logic               active_reg;
   logic               restart_reg;
   logic        [`ACT_IRQ_W-1:0] irq_stat_reg;
   logic        [`ACT_IRQ_W-1:0] irq_en_reg;

   // ************************************************************
   // bus decode
   // ************************************************************
   logic [`ACT_IDX_W-1:0] idx;
   logic                  wr;
   logic                  setup;
   logic [7:0]            wb;
   logic [7:0]            rd_byte;
   logic                  rd_hit;

   assign idx   = paddr[13:2];
   assign setup = clk_en && psel && !penable;
   assign wr    = clk_en && psel && penable && pwrite && pstrb[0];
   assign wb    = pwdata[7:0];
   assign pready = clk_en;

   function automatic logic hit_w(input logic [`ACT_IDX_W-1:0] a,
                                  input logic [`ACT_IDX_W-1:0] b);
      hit_w = (a == b);
   endfunction

   // ************************************************************
   // control fields
   // ************************************************************
   act_pkg::act_mode_t mode;
   act_pkg::act_dev_t  deviation_method;
   act_pkg::act_tmd_t  threshold_irq_select;
   logic [2:0]         shift_amount;
   logic               result_justify;
   logic               snapshot_source_sel;
   logic               tally_mode;

   assign mode                = act_pkg::act_mode_t'(ctrl0_reg[`ACT_CTRL0_MODE]);
   assign result_justify      = ctrl0_reg[`ACT_CTRL0_JUSTIFY];
   assign snapshot_source_sel = ctrl0_reg[`ACT_CTRL0_SNAPSHOT_SOURCE_SEL];
   assign shift_amount        = ctrl1_reg[`ACT_CTRL1_SHIFT];
   assign deviation_method                = act_pkg::act_dev_t'(ctrl1_reg[`ACT_CTRL1_DEVIATION_METHOD]);
   assign threshold_irq_select                 = act_pkg::act_tmd_t'(ctrl2_reg[`ACT_CTRL2_TMD]);
   assign tally_mode = (mode == act_pkg::ACT_MODE_AVG) ||
                       (mode == act_pkg::ACT_MODE_BURST) ||
                       (mode == act_pkg::ACT_MODE_LPF);

   // ************************************************************
   // computation datapath
   // ************************************************************
   logic        [15:0] res_next;
   logic signed [17:0] sum_base;
   logic signed [17:0] sum_next;
   logic signed [15:0] flt_next;
   logic signed [15:0] dev_next;
   logic               check_now;
   logic               below_next;
   logic               above_next;
   logic               tmd_hit;

   // left justify keeps msbs aligned, right keeps the raw count
   assign res_next = result_justify ? 16'(conv_data)
                   : {conv_data, {(16 - SAMPLE_W){1'b0}}};
   // averaging restarts the sum after a completed check
   assign sum_base = restart_reg ? 18'sh00000 : running_sum_reg;

   always_comb begin
      case (mode)
         act_pkg::ACT_MODE_ACCUM,
         act_pkg::ACT_MODE_AVG,
         act_pkg::ACT_MODE_BURST: begin
            sum_next = sum_base + $signed({2'b00, res_next});
         end
         act_pkg::ACT_MODE_LPF: begin
            sum_next = running_sum_reg - (running_sum_reg >>> shift_amount)
                     + $signed({2'b00, res_next});
         end
         default: begin
            sum_next = running_sum_reg;
         end
      endcase
   end

   always_comb begin
      case (mode)
         act_pkg::ACT_MODE_LPF: begin
            flt_next = 16'(sum_next >>> shift_amount);
         end
         act_pkg::ACT_MODE_ACCUM,
         act_pkg::ACT_MODE_AVG,
         act_pkg::ACT_MODE_BURST: begin
            flt_next = 16'(sum_next >>> shift_amount);
         end
         default: begin
            flt_next = filtered_out_reg;
         end
      endcase
   end

   always_comb begin
      case (deviation_method)
         act_pkg::ACT_DEV_RES_PREV: begin
            dev_next = $signed(res_next - last_sample_snapshot_reg);
         end
         act_pkg::ACT_DEV_RES_TGT: begin
            dev_next = $signed(res_next) - target_level_reg;
         end
         act_pkg::ACT_DEV_FLT_TGT: begin
            dev_next = flt_next - target_level_reg;
         end
         default: begin
            dev_next = flt_next - $signed(last_sample_snapshot_reg);
         end
      endcase
   end

   // limit of zero lets every conversion check
   assign check_now = conv_done &&
      (!tally_mode || trigger_tally_reg >= tally_limit_reg);
   assign below_next = dev_next < lower_bound_reg;
   assign above_next = dev_next > upper_bound_reg;

   always_comb begin
      case (threshold_irq_select)
         act_pkg::ACT_TMD_NEVER:     tmd_hit = 1'b0;
         act_pkg::ACT_TMD_BELOW:     tmd_hit = below_next;
         act_pkg::ACT_TMD_NOT_BELOW: tmd_hit = !below_next;
         act_pkg::ACT_TMD_OUTSIDE:   tmd_hit = below_next || above_next;
         act_pkg::ACT_TMD_INSIDE:    tmd_hit = !below_next && !above_next;
         act_pkg::ACT_TMD_ABOVE:     tmd_hit = above_next;
         act_pkg::ACT_TMD_NOT_ABOVE: tmd_hit = !above_next;
         default:                    tmd_hit = 1'b1;
      endcase
   end

   // ************************************************************
   // software-only registers
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lower_bound_reg     <= `ACT_RST_16;
         upper_bound_reg     <= `ACT_RST_16;
         target_level_reg    <= `ACT_RST_16;
         tally_limit_reg     <= `ACT_RST_8;
         extra_sample_pf_reg <= `ACT_RST_CAP;
         ctrl0_reg           <= `ACT_RST_8;
         ctrl1_reg           <= `ACT_RST_8;
         ctrl2_reg           <= `ACT_RST_8;
         irq_en_reg          <= `ACT_RST_IRQ;
      end else if (wr) begin
         if (hit_w(idx, `ACT_IDX_LTH_L)) lower_bound_reg[7:0]  <= wb;
         if (hit_w(idx, `ACT_IDX_LTH_H)) lower_bound_reg[15:8] <= wb;
         if (hit_w(idx, `ACT_IDX_UTH_L)) upper_bound_reg[7:0]  <= wb;
         if (hit_w(idx, `ACT_IDX_UTH_H)) upper_bound_reg[15:8] <= wb;
         if (hit_w(idx, `ACT_IDX_TGT_L)) target_level_reg[7:0]  <= wb;
         if (hit_w(idx, `ACT_IDX_TGT_H)) target_level_reg[15:8] <= wb;
         if (hit_w(idx, `ACT_IDX_LIMIT)) tally_limit_reg <= wb;
         if (hit_w(idx, `ACT_IDX_CAP))
            extra_sample_pf_reg <= wb[`ACT_CAP_W-1:0];
         if (hit_w(idx, `ACT_IDX_CTRL0)) ctrl0_reg <= wb;
         if (hit_w(idx, `ACT_IDX_CTRL1)) ctrl1_reg <= wb;
         if (hit_w(idx, `ACT_IDX_CTRL2)) ctrl2_reg <= wb;
         if (hit_w(idx, `ACT_IDX_IRQ_EN))
            irq_en_reg <= wb[`ACT_IRQ_W-1:0];
      end
   end

   assign extra_sample_pf = extra_sample_pf_reg;

   // ************************************************************
   // conversion activity
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         active_reg <= 1'b0;
      end else if (clk_en) begin
         if (conv_start) begin
            active_reg <= 1'b1;
         end else if (conv_done) begin
            active_reg <= 1'b0;
         end
      end
   end

   assign conversion_active = active_reg;

   // ************************************************************
   // sample and snapshot
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sample_value_reg         <= `ACT_RST_16;
         last_sample_snapshot_reg <= `ACT_RST_16;
      end else if (clk_en) begin
         if (conv_done) begin
            sample_value_reg <= res_next;
         end else if (wr && hit_w(idx, `ACT_IDX_RES_L)) begin
            sample_value_reg[7:0] <= wb;
         end else if (wr && hit_w(idx, `ACT_IDX_RES_H)) begin
            sample_value_reg[15:8] <= wb;
         end
         if (conv_start) begin
            last_sample_snapshot_reg <= snapshot_source_sel
               ? filtered_out_reg
               : sample_value_reg;
         end
      end
   end

   // ************************************************************
   // running sum and filter
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         running_sum_reg  <= `ACT_RST_SUM;
         filtered_out_reg <= `ACT_RST_16;
         restart_reg      <= 1'b0;
      end else if (clk_en) begin
         if (conv_done) begin
            running_sum_reg  <= sum_next;
            filtered_out_reg <= flt_next;
            restart_reg      <= check_now && tally_mode &&
                                (mode != act_pkg::ACT_MODE_LPF);
         end else if (wr && !active_reg) begin
            if (hit_w(idx, `ACT_IDX_SUM_L)) running_sum_reg[7:0] <= wb;
            if (hit_w(idx, `ACT_IDX_SUM_H)) running_sum_reg[15:8] <= wb;
            if (hit_w(idx, `ACT_IDX_SUM_U))
               running_sum_reg[17:16] <= wb[1:0];
         end
      end
   end

   // ************************************************************
   // trigger tally
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         trigger_tally_reg <= `ACT_RST_8;
      end else if (clk_en) begin
         if (wr && hit_w(idx, `ACT_IDX_TALLY)) begin
            trigger_tally_reg <= wb;
         end else if (tally_mode) begin
            if (check_now) begin
               trigger_tally_reg <= conv_start ? 8'h01 : 8'h00;
            end else if (conv_start) begin
               trigger_tally_reg <= trigger_tally_reg + 8'h01;
            end
         end
      end
   end

   // ************************************************************
   // threshold check and interrupt
   // ************************************************************
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         setpoint_deviation_reg <= `ACT_RST_16;
         below_low_flag         <= 1'b0;
         above_high_flag        <= 1'b0;
      end else if (clk_en && conv_done) begin
         setpoint_deviation_reg <= dev_next;
         if (check_now) begin
            below_low_flag  <= below_next;
            above_high_flag <= above_next;
         end
      end
   end

   logic [`ACT_IRQ_W-1:0] irq_set;
   logic [`ACT_IRQ_W-1:0] irq_clr;

   assign irq_set[`ACT_IRQ_THRESH] = check_now && tmd_hit;
   assign irq_set[`ACT_IRQ_DONE]   = conv_done;
   assign irq_clr = (wr && hit_w(idx, `ACT_IDX_IRQ_CLR))
                  ? wb[`ACT_IRQ_W-1:0] : `ACT_RST_IRQ;

   // set beats a clear landing in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_stat_reg <= `ACT_RST_IRQ;
      end else if (clk_en) begin
         irq_stat_reg <= irq_set | (irq_stat_reg & ~irq_clr);
      end
   end

   assign irq = |(irq_stat_reg & irq_en_reg);

   // ************************************************************
   // read mux
   // ************************************************************
   always_comb begin
      rd_hit  = 1'b1;
      rd_byte = 8'h00;
      case (idx)
         `ACT_IDX_LTH_L:    rd_byte = lower_bound_reg[7:0];
         `ACT_IDX_LTH_H:    rd_byte = lower_bound_reg[15:8];
         `ACT_IDX_UTH_L:    rd_byte = upper_bound_reg[7:0];
         `ACT_IDX_UTH_H:    rd_byte = upper_bound_reg[15:8];
         `ACT_IDX_ERR_L:    rd_byte = setpoint_deviation_reg[7:0];
         `ACT_IDX_ERR_H:    rd_byte = setpoint_deviation_reg[15:8];
         `ACT_IDX_TGT_L:    rd_byte = target_level_reg[7:0];
         `ACT_IDX_TGT_H:    rd_byte = target_level_reg[15:8];
         `ACT_IDX_FLT_L:    rd_byte = filtered_out_reg[7:0];
         `ACT_IDX_FLT_H:    rd_byte = filtered_out_reg[15:8];
         `ACT_IDX_SUM_L:    rd_byte = running_sum_reg[7:0];
         `ACT_IDX_SUM_H:    rd_byte = running_sum_reg[15:8];
         `ACT_IDX_SUM_U:    rd_byte = {{6{running_sum_reg[17]}},
                                       running_sum_reg[17:16]};
         `ACT_IDX_TALLY:    rd_byte = trigger_tally_reg;
         `ACT_IDX_LIMIT:    rd_byte = tally_limit_reg;
         `ACT_IDX_PREV_L:   rd_byte = last_sample_snapshot_reg[7:0];
         `ACT_IDX_PREV_H:   rd_byte = last_sample_snapshot_reg[15:8];
         `ACT_IDX_RES_L:    rd_byte = sample_value_reg[7:0];
         `ACT_IDX_RES_H:    rd_byte = sample_value_reg[15:8];
         `ACT_IDX_CAP:      rd_byte = 8'(extra_sample_pf_reg);
         `ACT_IDX_CTRL0:    rd_byte = ctrl0_reg;
         `ACT_IDX_CTRL1:    rd_byte = ctrl1_reg;
         `ACT_IDX_CTRL2:    rd_byte = ctrl2_reg;
         `ACT_IDX_STAT:     rd_byte = {5'h00, active_reg,
                                       above_high_flag, below_low_flag};
         `ACT_IDX_IRQ_STAT: rd_byte = 8'(irq_stat_reg);
         `ACT_IDX_IRQ_CLR:  rd_byte = 8'h00;
         `ACT_IDX_IRQ_EN:   rd_byte = 8'(irq_en_reg);
         default:           rd_hit  = 1'b0;
      endcase
   end

   // read data is captured in the setup cycle, one cycle ahead
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata  <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else if (setup) begin
         prdata  <= {24'h000000, rd_byte};
         pslverr <= !rd_hit;
      end
   end

endmodule

// file: verif/act_regs_properties.sv
// port-level checks for the computation register block
// assumes: bound to act_regs from the bench top file
`timescale 1ns/1ps
`include "act_params.svh"

module act_regs_check #(
   parameter int SAMPLE_W = 12
) (
   input wire logic        pclk,
   input wire logic        presetn,
   input wire logic        clk_en,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [13:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0]  pstrb,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        conv_start,
   input wire logic        conv_done,
   input wire logic [4:0]  extra_sample_pf,
   input wire logic        conversion_active,
   input wire logic        irq
);
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic unmapped(input logic [11:0] i);
      return !((i >= `ACT_IDX_CTRL0 && i <= `ACT_IDX_IRQ_EN) ||
               (i >= `ACT_IDX_LTH_L && i <= `ACT_IDX_RES_H) ||
               i == `ACT_IDX_CAP);
   endfunction
   logic acc_w;
   assign acc_w = psel && penable && pwrite && clk_en && pstrb[0];

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   // ************************************************************
   // properties
   // ************************************************************
   ready_follow_a: assert property (pready == clk_en)
      else $error("pready differs from clk_en");
   err_unmapped_a: assert property (
      psel && !penable && clk_en |=> pslverr == unmapped($past(paddr[13:2])))
      else $error("pslverr wrong for address");
   unmapped_zero_a: assert property (
      psel && !penable && clk_en && unmapped(paddr[13:2]) |=> prdata == 0)
      else $error("unmapped read not zero");
   cap_write_a: assert property (
      acc_w && paddr[13:2] == `ACT_IDX_CAP
      |=> extra_sample_pf == $past(pwdata[4:0]))
      else $error("capacitance select not written");
   active_set_a: assert property (
      conv_start && clk_en |=> conversion_active)
      else $error("conversion not marked active");
   active_clear_a: assert property (
      conv_done && !conv_start && clk_en |=> !conversion_active)
      else $error("conversion still active");
   freeze_hold_a: assert property (!clk_en |=> $stable(conversion_active)
      && $stable(prdata) && $stable(pslverr))
      else $error("state moved with clk_en low");
   irq_clear_a: assert property (
      acc_w && paddr[13:2] == `ACT_IDX_IRQ_CLR && pwdata[1:0] == 2'h3
      && !conv_done |=> !irq)
      else $error("interrupt not cleared");
   irq_cause_a: assert property (
      $rose(irq) |-> $past(conv_done) || $past(acc_w))
      else $error("interrupt rose without cause");
endmodule

// file: verif/act_regs_test.sv
// self-checking bench for the computation register block
// assumes: act_pkg, act_regs and the checker compiled before this file
`timescale 1ns/1ps
`include "act_params.svh"
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin \
   n_fail++; $display("ERROR %s expected %h seen %h", nm, e, g); end end

module act_regs_test;
   logic        pclk, presetn, clk_en, psel, penable, pwrite;
   logic [13:0] paddr;
   logic [31:0] pwdata, prdata;
   logic [3:0]  pstrb;
   logic        pready, pslverr, conv_start, conv_done, conversion_active;
   logic        irq, err;
   logic [11:0] conv_data;
   logic [4:0]  extra_sample_pf;
   logic [7:0]  q;
   logic [7:0]  tmd_tab = 8'hCA;
   int          n_fail = 0;
   int          total_checks = 0;

   act_regs #(.SAMPLE_W(12)) dut (.pclk(pclk), .presetn(presetn),
      .clk_en(clk_en), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .conv_start(conv_start),
      .conv_done(conv_done), .conv_data(conv_data),
      .extra_sample_pf(extra_sample_pf),
      .conversion_active(conversion_active), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // ************************************************************
   // bus and converter tasks
   // ************************************************************
   task automatic conclude();
      if (n_fail == 0 && total_checks > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   task automatic apb(input logic w, input logic [11:0] i,
                      input logic [7:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= {i, 2'b00};
      pwdata  <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         n_fail++;
         conclude();
      end
      q       = prdata[7:0];
      err     = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] i, input logic [7:0] d);
      apb(1'b1, i, d);
   endtask

   task automatic rd(input logic [11:0] i, input logic [7:0] e,
                     input string nm);
      apb(1'b0, i, 8'h00);
      `CHK(nm, e, q)
   endtask

   task automatic go();
      @(posedge pclk);
      conv_start <= 1'b1;
      @(posedge pclk);
      conv_start <= 1'b0;
   endtask

   task automatic done(input logic [11:0] d);
      @(posedge pclk);
      conv_done <= 1'b1;
      conv_data <= d;
      @(posedge pclk);
      conv_done <= 1'b0;
      conv_data <= ~d;
      @(posedge pclk);
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_regs();
      rd(`ACT_IDX_LTH_H, 8'h00, "lower_bound");
      rd(`ACT_IDX_TALLY, 8'h00, "tally");
      rd(`ACT_IDX_PREV_H, 8'h00, "snapshot");
      rd(12'h3D7, 8'h00, "unmapped");
      `CHK("unmapped_err", 1'b1, err)
      wr(`ACT_IDX_CAP, 8'h1F);
      // pin settles after the write edge
      @(negedge pclk);
      `CHK("cap_pin", 5'h1F, extra_sample_pf)
      rd(`ACT_IDX_CAP, 8'h1F, "cap_reg");
   endtask

   task automatic t_accum();
      wr(`ACT_IDX_CTRL0, 8'h09);
      wr(`ACT_IDX_CTRL1, 8'h02);
      wr(`ACT_IDX_SUM_L, 8'h10);
      go();
      wr(`ACT_IDX_SUM_L, 8'hFF);
      `CHK("active", 1'b1, conversion_active)
      rd(`ACT_IDX_SUM_L, 8'h10, "sum_busy");
      done(12'h00C);
      `CHK("idle", 1'b0, conversion_active)
      rd(`ACT_IDX_SUM_L, 8'h1C, "sum");
      rd(`ACT_IDX_FLT_L, 8'h07, "filtered");
      wr(`ACT_IDX_SUM_U, 8'h03);
      rd(`ACT_IDX_SUM_U, 8'hFF, "sum_sign");
      wr(`ACT_IDX_SUM_U, 8'h00);
   endtask

   task automatic t_thresh();
      wr(`ACT_IDX_CTRL0, 8'h08);
      wr(`ACT_IDX_CTRL1, 8'h10);
      wr(`ACT_IDX_TGT_L, 8'h10);
      wr(`ACT_IDX_LTH_L, 8'hFE);
      wr(`ACT_IDX_LTH_H, 8'hFF);
      wr(`ACT_IDX_UTH_L, 8'h05);
      wr(`ACT_IDX_IRQ_EN, 8'h01);
      go();
      done(12'h008);
      rd(`ACT_IDX_PREV_L, 8'h0C, "snapshot");
      rd(`ACT_IDX_ERR_H, 8'hFF, "dev_hi");
      rd(`ACT_IDX_ERR_L, 8'hF8, "dev_lo");
      rd(`ACT_IDX_STAT, 8'h01, "flags");
      for (int k = 0; k < 8; k++) begin
         wr(`ACT_IDX_CTRL2, k[7:0]);
         wr(`ACT_IDX_IRQ_CLR, 8'h03);
         @(posedge pclk);
         `CHK("irq_clear", 1'b0, irq)
         go();
         done(12'h008);
         `CHK("irq_select", tmd_tab[k], irq)
      end
   endtask

   task automatic t_tally();
      wr(`ACT_IDX_CTRL0, 8'h1A);
      wr(`ACT_IDX_CTRL1, 8'h11);
      wr(`ACT_IDX_LIMIT, 8'h02);
      wr(`ACT_IDX_SUM_L, 8'h00);
      wr(`ACT_IDX_TALLY, 8'h00);
      wr(`ACT_IDX_IRQ_CLR, 8'h03);
      go();
      done(12'h020);
      rd(`ACT_IDX_TALLY, 8'h01, "tally");
      `CHK("irq_early", 1'b0, irq)
      rd(`ACT_IDX_FLT_L, 8'h10, "filtered");
      go();
      done(12'h020);
      `CHK("irq_check", 1'b1, irq)
      rd(`ACT_IDX_TALLY, 8'h00, "tally_restart");
      rd(`ACT_IDX_PREV_L, 8'h10, "snapshot");
      wr(`ACT_IDX_CTRL0, 8'h08);
      wr(`ACT_IDX_TALLY, 8'h05);
      go();
      done(12'h020);
      rd(`ACT_IDX_TALLY, 8'h05, "tally_basic");
      wr(`ACT_IDX_CTRL0, 8'h0C);
      go();
      done(12'h010);
      rd(`ACT_IDX_FLT_L, 8'h18, "lpf");
      wr(`ACT_IDX_CTRL0, 8'h0B);
      go();
      done(12'h010);
      rd(`ACT_IDX_FLT_L, 8'h20, "burst");
   endtask

   initial begin
      {presetn, psel, penable, pwrite, conv_start, conv_done} = 6'h00;
      paddr     = 14'h0000;
      pwdata    = 32'h00000000;
      pstrb     = 4'hF;
      conv_data = 12'h000;
      clk_en    = 1'b1;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      clk_en <= 1'b0;
      repeat (3) @(posedge pclk);
      clk_en <= 1'b1;
      t_regs();
      t_accum();
      t_thresh();
      t_tally();
      conclude();
   end
endmodule

bind act_regs act_regs_check #(.SAMPLE_W(SAMPLE_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .clk_en(clk_en), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .conv_start(conv_start), .conv_done(conv_done),
   .extra_sample_pf(extra_sample_pf),
   .conversion_active(conversion_active), .irq(irq));
